// ### logic/pbl_pkg.sv
package pbl_pkg;

  // Clock rate and time base
  localparam int CLOCK_HZ = 10_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES_DEF = CLOCK_HZ / 1_000_000 * TICK_US;

  // Interval figures in milliseconds and pulse-width factors
  localparam int DEBOUNCE_MS = 50;
  localparam int LONG_PRESS_MS = 8000;
  localparam int EVENT_MS = 32;
  localparam int EXT_FACTOR = 4;
  localparam int LOCK_FACTOR = 2;

  // Counter widths
  localparam int TICK_W = 16;
  localparam int PRESS_W = 16;
  localparam int PULSE_W = 8;

  // Interval figures as tick counts
  localparam int MS_PER_TICK = TICK_US / 1000;
  localparam logic [PRESS_W-1:0] DEBOUNCE_TICKS =
    PRESS_W'(DEBOUNCE_MS / MS_PER_TICK);
  localparam int LONG_TICKS_DEF = LONG_PRESS_MS / MS_PER_TICK;
  localparam logic [PULSE_W-1:0] EVENT_TICKS =
    PULSE_W'(EVENT_MS / MS_PER_TICK);
  localparam logic [PULSE_W-1:0] EXT_TICKS =
    PULSE_W'(EXT_FACTOR * EVENT_MS / MS_PER_TICK);
  localparam logic [PULSE_W-1:0] LOCK_TICKS =
    PULSE_W'(LOCK_FACTOR * EVENT_MS / MS_PER_TICK);

  localparam logic [TICK_W-1:0] TICK_ONE = 16'h0001;
  localparam logic [PRESS_W-1:0] PRESS_ONE = 16'h0001;
  localparam logic [PULSE_W-1:0] PULSE_ONE = 8'h01;

  typedef enum logic [1:0] {
    PBL_IDLE,
    PBL_DEBOUNCE,
    PBL_HELD,
    PBL_DONE
  } pbl_state_t;

endpackage : pbl_pkg

// ### logic/pbl_onoff_latch.sv
// Functional notes
// - The power enable rises once the button has been held low for the whole debounce interval.
// - Each debounced closure starts one active-low event pulse of the nominal width.
// - A closure lasting past the long-press interval gives a longer event pulse.
// - In the clearing variant a long press drops the power enable, shorter presses leave it set.
// - In the holding variant the power enable stays set however long the press lasts.
// - Outside the lockout, pulling the force-off input low drops the power enable at once, with no clock edge.
// - A force-off while the power enable is already low leaves it low.
// - The event pin is open-drain, driven low only during a pulse and released otherwise.
// - The power enable is an active-high level held between button and force-off events.
// - The button input is active low and an open, pulled-up button reads as released.
// - For twice the nominal pulse width after the power enable rises, force-off is ignored.
// - The extended event pulse lasts four times the nominal pulse width.
// - Holding on past the extended pulse gives no further pulse until release and a new press.
// - Force-off has no effect on the event pin and a running pulse carries on.
`timescale 1ns/1ns
module pbl_onoff_latch
  import pbl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int LONG_TICKS = LONG_TICKS_DEF,
  parameter bit CLEAR_ON_LONG = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_button_n,
  input wire logic i_force_off_n,
  input wire logic i_event_in,
  output logic o_event_out,
  output logic o_event_oe_n,
  output logic o_power_en
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [PRESS_W-1:0] LONG_LAST = PRESS_W'(LONG_TICKS);

  function automatic logic reached(input logic [PRESS_W-1:0] cnt,
                                   input logic [PRESS_W-1:0] lim);
    reached = (cnt == lim);
  endfunction : reached

  logic [TICK_W-1:0] tick_cnt_r;
  logic tick;
  logic pressed;
  pbl_state_t state_r;
  logic [PRESS_W-1:0] press_cnt_r;
  logic accept_evt;
  logic long_evt;
  logic latch_r;
  logic lockout_r;
  logic [PULSE_W-1:0] lock_cnt_r;
  logic clr_gate_n;
  logic pulse_active_r;
  logic [PULSE_W-1:0] pulse_len_r;
  logic [PULSE_W-1:0] pulse_cnt_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TICK_ONE;
    end
  end

  assign tick = (tick_cnt_r == TICK_LAST);

  assign pressed = ~i_button_n;

  // Counter keeps running from press start, so long press includes debounce
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= PBL_IDLE;
      press_cnt_r <= '0;
    end else begin
      case (state_r)
        PBL_IDLE: begin
          press_cnt_r <= '0;
          if (pressed) begin
            state_r <= PBL_DEBOUNCE;
          end
        end
        PBL_DEBOUNCE: begin
          if (!pressed) begin
            state_r <= PBL_IDLE;
            press_cnt_r <= '0;
          end else if (tick) begin
            if (reached(press_cnt_r, DEBOUNCE_TICKS)) begin
              state_r <= PBL_HELD;
            end
            press_cnt_r <= press_cnt_r + PRESS_ONE;
          end
        end
        PBL_HELD: begin
          if (!pressed) begin
            state_r <= PBL_IDLE;
          end else if (tick) begin
            if (reached(press_cnt_r, LONG_LAST)) begin
              state_r <= PBL_DONE;
            end
            press_cnt_r <= press_cnt_r + PRESS_ONE;
          end
        end
        PBL_DONE: begin
          if (!pressed) begin
            state_r <= PBL_IDLE;
          end
        end
        default: begin
          state_r <= PBL_IDLE;
        end
      endcase
    end
  end

  // Firing on the tick after the count is met gives at least a full interval
  assign accept_evt = (state_r == PBL_DEBOUNCE) && pressed && tick &&
                      reached(press_cnt_r, DEBOUNCE_TICKS);
  assign long_evt = (state_r == PBL_HELD) && pressed && tick &&
                    reached(press_cnt_r, LONG_LAST);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lockout_r <= 1'b0;
      lock_cnt_r <= '0;
    end else if (accept_evt && !latch_r) begin
      lockout_r <= 1'b1;
      lock_cnt_r <= '0;
    end else if (lockout_r && tick) begin
      if (lock_cnt_r == LOCK_TICKS) begin
        lockout_r <= 1'b0;
      end
      lock_cnt_r <= lock_cnt_r + PULSE_ONE;
    end
  end

  // Gate is force-off ORed with the lockout flop, so lockout masks the clear
  assign clr_gate_n = i_force_off_n | lockout_r;

  always_ff @(posedge i_clock or negedge clr_gate_n) begin
    if (!clr_gate_n) begin
      latch_r <= 1'b0;
    end else if (!i_rst_n) begin
      latch_r <= 1'b0;
    end else if (accept_evt) begin
      latch_r <= 1'b1;
    end else if (long_evt && CLEAR_ON_LONG) begin
      latch_r <= 1'b0;
    end
  end

  assign o_power_en = latch_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pulse_active_r <= 1'b0;
      pulse_len_r <= EVENT_TICKS;
      pulse_cnt_r <= '0;
    end else if (long_evt) begin
      pulse_active_r <= 1'b1;
      pulse_len_r <= EXT_TICKS;
      pulse_cnt_r <= '0;
    end else if (accept_evt) begin
      pulse_active_r <= 1'b1;
      pulse_len_r <= EVENT_TICKS;
      pulse_cnt_r <= '0;
    end else if (pulse_active_r && tick) begin
      if (pulse_cnt_r == pulse_len_r) begin
        pulse_active_r <= 1'b0;
      end
      pulse_cnt_r <= pulse_cnt_r + PULSE_ONE;
    end
  end

  assign o_event_out = 1'b0;
  assign o_event_oe_n = ~pulse_active_r;

  // Assertions
  sequence s_accept;
    accept_evt;
  endsequence

  sequence s_long;
    long_evt;
  endsequence

  a_set_on_debounce: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_accept ##0 clr_gate_n |=> latch_r
  ) else $error("power enable not set after debounce");

  a_no_early_set: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !latch_r && !accept_evt |=> !latch_r
  ) else $error("power enable rose without debounce");

  a_pulse_start: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_accept ##0 !long_evt |=> !o_event_oe_n && pulse_len_r == EVENT_TICKS
  ) else $error("nominal event pulse did not start");

  a_ext_pulse: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_long |=> !o_event_oe_n && pulse_len_r == EXT_TICKS &&
               pulse_cnt_r == '0
  ) else $error("extended event pulse not started");

  a_long_clear: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_long ##0 CLEAR_ON_LONG |=> !latch_r
  ) else $error("long press did not clear power enable");

  a_long_hold: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    s_long ##0 !CLEAR_ON_LONG ##0 latch_r ##0 i_force_off_n |=>
      latch_r
  ) else $error("holding variant dropped power enable");

  a_force_off: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !i_force_off_n && !lockout_r |-> !latch_r
  ) else $error("force-off did not drop power enable");

  a_lockout_rise: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    $rose(latch_r) |-> lockout_r
  ) else $error("no lockout after power enable rise");

  a_lockout_keep: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    lockout_r && latch_r && !long_evt &&
      !(tick && lock_cnt_r == LOCK_TICKS) |=> latch_r
  ) else $error("force-off acted during lockout");

  a_no_repeat: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    state_r == PBL_DONE |-> !accept_evt && !long_evt
  ) else $error("extra event while still held");

  a_pulse_end: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    pulse_active_r && tick && pulse_cnt_r == pulse_len_r &&
      !accept_evt && !long_evt |=> o_event_oe_n
  ) else $error("event pulse did not end on time");

  a_pulse_kept: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    $fell(i_force_off_n) && pulse_active_r && !tick |=> pulse_active_r
  ) else $error("force-off disturbed event pulse");

  a_od_level: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !o_event_oe_n |-> !o_event_out && pulse_active_r
  ) else $error("event pin driven outside a pulse");

  a_stay_low: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !latch_r && !clr_gate_n |=> !latch_r
  ) else $error("force-off raised power enable");

  a_bounce_restart: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    state_r == PBL_DEBOUNCE && !pressed |=>
      state_r == PBL_IDLE && press_cnt_r == '0
  ) else $error("debounce count not restarted");

  a_idle_stay: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    state_r == PBL_IDLE && i_button_n |=> state_r == PBL_IDLE
  ) else $error("released button left idle");

  a_done_quiet: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    state_r == PBL_DONE && pressed |=> state_r == PBL_DONE
  ) else $error("held button left done state");

  a_tick_wrap: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    tick |=> tick_cnt_r == '0
  ) else $error("tick counter did not wrap");

  a_pulse_bound: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    pulse_active_r |-> pulse_cnt_r <= pulse_len_r
  ) else $error("event pulse count overran");

  a_lock_bound: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    lockout_r |-> lock_cnt_r <= LOCK_TICKS
  ) else $error("lockout count overran");

endmodule : pbl_onoff_latch

// ### bench/pbl_switch_model.sv
`timescale 1ns/1ns
module pbl_switch_model (
  input wire logic i_press,
  input wire logic i_event_oe_n,
  input wire logic i_event_out,
  output logic o_button_n,
  output logic o_event_wire
);
  assign o_button_n = i_press ? 1'b0 : 1'b1;
  assign o_event_wire = (i_event_oe_n === 1'b0) ? i_event_out : 1'b1;
endmodule : pbl_switch_model

// ### bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import pbl_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_force_off_n = 1'b1;
  logic press = 1'b0;
  logic button_n, ev_wire, ev_wire_h, oe_c, oe_h, out_c, out_h, pwr_c, pwr_h;
  logic prev, prev_h;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 32'he0de;
  int rise, lo1, hi1, lo2, hi2, fall, lows, lows_h, h;
  // Default build is the clearing variant
  pbl_onoff_latch #(.TICK_CYCLES(4),
    .LONG_TICKS(100)) pbl_onoff_latch_inst (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_button_n(button_n),
    .i_force_off_n(i_force_off_n), .i_event_in(ev_wire),
    .o_event_out(out_c), .o_event_oe_n(oe_c), .o_power_en(pwr_c));
  // Holding variant shares the button, own pulled-up event pin
  pbl_onoff_latch #(.TICK_CYCLES(4), .LONG_TICKS(100),
    .CLEAR_ON_LONG(1'b0)) pbl_onoff_latch_hold_inst (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_button_n(button_n),
    .i_force_off_n(i_force_off_n), .i_event_in(ev_wire_h),
    .o_event_out(out_h), .o_event_oe_n(oe_h), .o_power_en(pwr_h));
  pbl_switch_model pbl_switch_model_inst (.i_press(press),
    .i_event_oe_n(oe_c), .i_event_out(out_c), .o_button_n(button_n),
    .o_event_wire(ev_wire));
  pbl_switch_model pbl_switch_model_hold_inst (.i_press(press),
    .i_event_oe_n(oe_h), .i_event_out(out_h), .o_button_n(),
    .o_event_wire(ev_wire_h));
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic check_bit(string name, logic exp, logic got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit
  task automatic check_rng(string name, int lo, int hi, int got);
    tests_run++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi,
        got);
    end
  endtask : check_rng
  // Press for hold cycles, force-off low from force_at, record edges
  task automatic run_press(int hold, int force_at, int span);
    rise = -1; lo1 = -1; hi1 = -1; lo2 = -1; hi2 = -1; fall = -1;
    lows = 0;
    prev = 1'b1;
    lows_h = 0;
    prev_h = 1'b1;
    for (int c = 0; c < span; c++) begin
      @(negedge i_clock);
      if (rise < 0 && pwr_c === 1'b1) rise = c;
      if (rise >= 0 && fall < 0 && pwr_c === 1'b0) fall = c;
      if (ev_wire === 1'b0) begin
        if (prev === 1'b1) lows++;
        if (lo1 < 0) lo1 = c;
        else if (hi1 >= 0 && lo2 < 0) lo2 = c;
      end else begin
        if (lo1 >= 0 && hi1 < 0) hi1 = c;
        else if (lo2 >= 0 && hi2 < 0) hi2 = c;
      end
      prev = ev_wire;
      if (ev_wire_h === 1'b0 && prev_h === 1'b1) lows_h++;
      prev_h = ev_wire_h;
      press <= (c < hold);
      i_force_off_n <= !(force_at >= 0 && c >= force_at);
    end
    // One more edge, so no input is driven twice in one step
    @(negedge i_clock);
    press <= 1'b0;
    i_force_off_n <= 1'b1;
  endtask : run_press
  initial begin
    #2_000_000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (4) @(negedge i_clock);
    i_rst_n = 1'b1;
    check_bit("power_en", 1'b0, pwr_c);
    check_bit("event_oe_n", 1'b1, oe_c);
    check_bit("event_wire", 1'b1, ev_wire);
    run_press(0, 0, 20);
    check_bit("power_en", 1'b0, pwr_c);
    for (int i = 0; i < 6; i++) begin
      h = (i == 0) ? 190 : 20 + ($random(seed) & 32'h7F);
      run_press(h, -1, h + 40);
      check_rng("bounce_rise", -1, -1, rise);
    end
    // Force-off held from just after rise, through lockout
    run_press(300, 215, 700);
    check_rng("debounce", 198, 210, rise);
    check_rng("pulse_start", 0, 2, lo1 - rise);
    check_rng("pulse_len", 126, 138, hi1 - lo1);
    check_rng("lockout", 254, 266, fall - rise);
    check_bit("event_out", 1'b0, out_c);
    run_press(250, -1, 600);
    check_bit("power_en", 1'b1, pwr_c);
    @(negedge i_clock);
    i_force_off_n <= 1'b0;
    #1;
    check_bit("power_async", 1'b0, pwr_c);
    check_bit("power_async_h", 1'b0, pwr_h);
    @(negedge i_clock);
    i_force_off_n <= 1'b1;
    run_press(1000, -1, 1200);
    check_rng("long_clear", 398, 412, fall);
    check_bit("power_hold", 1'b1, pwr_h);
    check_rng("ext_len", 510, 522, hi2 - lo2);
    check_rng("pulse_count", 2, 2, lows);
    check_rng("pulse_count_h", 2, 2, lows_h);
    run_press(260, -1, 500);
    check_rng("repress_pulse", 126, 138, hi1 - lo1);
    check_rng("repress_count_h", 1, 1, lows_h);
    end_of_test();
  end
endmodule : testbench
